// file: hw/dbc_core.sv
// Command decode, bank state, burst and refresh logic of the DRAM device
// What this block does
// - ACTIVE opens row A0-A12 in chosen bank
// - READ takes bank, column; A10 auto precharge
// - Write bytes stored only where DM low
// - PRECHARGE A10 high closes all banks
// - Idle after tRP; access needs fresh ACTIVE
// - PRECHARGE to idle or precharging bank ignored
// - Other-bank access allowed during auto precharge
// - Burst terminate cuts latest non-precharge burst
// - Auto refresh uses internal row counter
// - Refresh code with CKE low: self refresh
// - Self refresh covers selected array portion only
// - Deep power-down loses all stored data
// - Auto precharge waits for tRAS minimum
// - Read data after CAS latency, DQS strobed
// - Data lines released after burst ends
// - READ may follow READ any cycle
// - Command decoded from four strobe levels
// - Terminate code with CKE low: deep power-down
// - Partial-array choices full to sixteenth
`timescale 1ns/1ps
`include "dbc_consts.svh"
module dbc_core (
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_cke,
    input wire dbc_pkg::dbc_cmd_s i_cmd,
    input wire logic [1:0] i_ba,
    input wire logic [12:0] i_addr,
    input wire logic [15:0] i_dq,
    input wire logic [1:0] i_dm,
    input wire logic i_rd_ready,
    input wire logic [2:0] i_partial_array_refresh_select,
    output logic [15:0] o_dq,
    output logic o_dq_oe,
    output logic o_dqs,
    output logic o_dqs_oe,
    output logic o_rd_valid,
    output logic [3:0] o_bank_open,
    output logic o_rfsh_pulse,
    output logic [14:0] o_rfsh_addr,
    output logic o_self_refresh,
    output logic o_power_down
);

    dbc_pkg::dbc_core_s r;
    dbc_pkg::dbc_core_s n;

    logic [2:0] op;
    logic go;
    logic pop;
    logic push;
    logic fetch;
    logic [1:0] occ;
    logic [15:0] word;
    logic [15:0] mem_q;
    logic [5:0] raddr;
    logic [5:0] waddr;
    logic mem_we;

    // Storage index from bank, top two row bits and column
    function automatic logic [5:0] midx(input logic [1:0] ba, input logic [12:0] row,
                                        input logic [1:0] col);
        midx = {ba, row[12:11], col};
    endfunction

    // Whether a bank and row region is kept in self refresh
    function automatic logic partial_array_refresh_select_keep(input logic [2:0] sel, input logic [1:0] ba,
                                       input logic [1:0] rtop);
        case (sel)
            `DBC_PARTIAL_ARRAY_REFRESH_SELECT_FULL: partial_array_refresh_select_keep = 1'b1;
            `DBC_PARTIAL_ARRAY_REFRESH_SELECT_HALF: partial_array_refresh_select_keep = ~ba[1];
            `DBC_PARTIAL_ARRAY_REFRESH_SELECT_QUARTER: partial_array_refresh_select_keep = (ba == 2'h0);
            `DBC_PARTIAL_ARRAY_REFRESH_SELECT_EIGHTH: partial_array_refresh_select_keep = (ba == 2'h0) & ~rtop[1];
            `DBC_PARTIAL_ARRAY_REFRESH_SELECT_SIXTEENTH: partial_array_refresh_select_keep = (ba == 2'h0) & (rtop == 2'h0);
            default: partial_array_refresh_select_keep = 1'b1;
        endcase
    endfunction

    // Start a precharge unless the bank is idle or already closing
    function automatic dbc_pkg::dbc_bank_s do_pre(input dbc_pkg::dbc_bank_s bk);
        do_pre = bk;
        if (bk.open && !bk.pre) begin
            do_pre.open = 1'b0;
            do_pre.ap = 1'b0;
            do_pre.pre = 1'b1;
            do_pre.tmr = 4'(`DBC_RP_CYC);
        end
    endfunction

    // Command strobe, only in normal mode with CKE high
    assign op = {i_cmd.ras_n, i_cmd.cas_n, i_cmd.we_n};
    assign go = ~i_cmd.cs_n & i_cke & (r.mode == dbc_pkg::DBC_NORM);

    // Two-entry read buffer handshake
    assign push = r.infl;
    assign word = r.infl_ok ? mem_q : 16'h0000;
    assign pop = (r.lat == 2'(`DBC_CAS_LAT)) & (r.bcnt != 2'h0) & i_rd_ready;
    assign occ = r.bcnt + {1'b0, r.infl} - {1'b0, pop};
    assign fetch = r.rd_on & (occ < 2'h2);

    // Storage addresses of the running bursts
    assign raddr = midx(r.rd_ba, r.bank[r.rd_ba].row, r.rd_col[1:0] + r.rd_cnt[1:0]);
    assign waddr = midx(r.wr_ba, r.bank[r.wr_ba].row, r.wr_col[1:0] + r.wr_cnt[1:0]);
    assign mem_we = r.wr_on & r.bank[r.wr_ba].open;

    dbc_mem u_mem (
        .i_mclk(i_mclk),
        .i_resetn(i_resetn),
        .i_we(mem_we),
        .i_be(~i_dm),
        .i_waddr(waddr),
        .i_wdata(i_dq),
        .i_re(fetch),
        .i_raddr(raddr),
        .o_rdata(mem_q)
    );

    // Next state of the whole block
    always_comb begin
        n = r;
        n.rf_pulse = 1'b0;
        n.rd_vld = 1'b0;
        n.infl = fetch;
        n.infl_ok = r.valid[raddr];

        // Bank timers and auto precharge start
        for (int b = 0; b < 4; b++) begin
            if (r.bank[b].ras != 4'h0) begin
                n.bank[b].ras = r.bank[b].ras - 4'h1;
            end
            if (r.bank[b].pre) begin
                n.bank[b].tmr = r.bank[b].tmr - 4'h1;
                if (r.bank[b].tmr <= 4'h1) begin
                    n.bank[b].pre = 1'b0;
                end
            end
            if (r.bank[b].ap && r.bank[b].ras == 4'h0) begin
                n.bank[b] = do_pre(r.bank[b]);
            end
        end

        // Read fetch into the buffer
        if (fetch) begin
            n.rd_cnt = r.rd_cnt + 3'h1;
            if (r.rd_cnt == 3'(`DBC_BL - 1)) begin
                n.rd_on = 1'b0;
                if (r.rd_ap) begin
                    n.bank[r.rd_ba].ap = 1'b1;
                end
            end
        end

        // Buffer push and pop
        case ({push, pop})
            2'b10: begin
                n.buf_d[r.bcnt[0]] = word;
                n.bcnt = r.bcnt + 2'h1;
            end
            2'b01: begin
                n.buf_d[0] = r.buf_d[1];
                n.bcnt = r.bcnt - 2'h1;
            end
            2'b11: begin
                n.buf_d[0] = (r.bcnt == 2'h1) ? word : r.buf_d[1];
                n.buf_d[1] = word;
            end
            default: begin
            end
        endcase

        // Latency count, preamble, data and postamble
        if (r.lat != 2'h0 && r.lat != 2'(`DBC_CAS_LAT)) begin
            n.lat = r.lat + 2'h1;
        end
        if (r.lat == 2'(`DBC_CAS_LAT - 1)) begin
            n.dqs_oe = 1'b1;
            n.dqs = 1'b0;
        end
        if (pop) begin
            n.dq = r.buf_d[0];
            n.dq_oe = 1'b1;
            n.dqs = ~r.dqs;
            n.rd_vld = 1'b1;
        end
        if (r.lat == 2'(`DBC_CAS_LAT) && r.bcnt == 2'h0 && !r.rd_on && !r.infl) begin
            n.lat = 2'h0;
            n.dq_oe = 1'b0;
            n.dq = 16'h0000;
            n.dqs = 1'b0;
        end
        if (r.lat == 2'h0 && !r.dq_oe) begin
            n.dqs_oe = 1'b0;
        end

        // Write burst, one word a cycle
        if (r.wr_on) begin
            n.wr_cnt = r.wr_cnt + 3'h1;
            if (mem_we && i_dm != 2'h3) begin
                n.valid[waddr] = 1'b1;
            end
            if (r.wr_cnt == 3'(`DBC_BL - 1)) begin
                n.wr_on = 1'b0;
                if (r.wr_ap) begin
                    n.bank[r.wr_ba].ap = 1'b1;
                end
            end
        end

        // Commands in normal mode
        if (go) begin
            case (op)
                `DBC_OP_ACT: begin
                    if (!r.bank[i_ba].open && !r.bank[i_ba].pre) begin
                        n.bank[i_ba].open = 1'b1;
                        n.bank[i_ba].row = i_addr;
                        n.bank[i_ba].ras = 4'(`DBC_RAS_CYC);
                    end
                end
                `DBC_OP_READ: begin
                    if (r.bank[i_ba].open) begin
                        n.rd_on = 1'b1;
                        n.rd_ba = i_ba;
                        n.rd_col = i_addr[`DBC_COL_W-1:0];
                        n.rd_cnt = 3'h0;
                        n.rd_ap = i_addr[`DBC_A_AP];
                        n.last_wr = 1'b0;
                        if (n.lat == 2'h0) begin
                            n.lat = 2'h1;
                        end
                    end
                end
                `DBC_OP_WRITE: begin
                    if (r.bank[i_ba].open) begin
                        n.wr_on = 1'b1;
                        n.wr_ba = i_ba;
                        n.wr_col = i_addr[`DBC_COL_W-1:0];
                        n.wr_cnt = 3'h0;
                        n.wr_ap = i_addr[`DBC_A_AP];
                        n.last_wr = 1'b1;
                    end
                end
                `DBC_OP_PRE: begin
                    if (i_addr[`DBC_A_AP]) begin
                        for (int b = 0; b < 4; b++) begin
                            n.bank[b] = do_pre(r.bank[b]);
                        end
                    end else begin
                        n.bank[i_ba] = do_pre(r.bank[i_ba]);
                    end
                end
                `DBC_OP_REF: begin
                    n.mode = dbc_pkg::DBC_AREF;
                    n.mtmr = 8'(`DBC_RFC_CYC);
                    n.rfa = r.rfc;
                    n.rfc = r.rfc + 15'h0001;
                    n.rf_pulse = 1'b1;
                end
                `DBC_OP_BST: begin
                    if (r.last_wr && !r.wr_ap) begin
                        n.wr_on = 1'b0;
                    end else if (!r.last_wr && !r.rd_ap) begin
                        n.rd_on = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        // Power and refresh modes
        case (r.mode)
            dbc_pkg::DBC_NORM: begin
                if (!i_cmd.cs_n && !i_cke && op == `DBC_OP_REF) begin
                    n.mode = dbc_pkg::DBC_SREF;
                    n.mtmr = 8'(`DBC_REFI_CYC);
                    n.rd_on = 1'b0;
                    n.wr_on = 1'b0;
                    for (int i = 0; i < 64; i++) begin
                        if (!partial_array_refresh_select_keep(i_partial_array_refresh_select,
                                       2'(i >> 4), 2'(i >> 2))) begin
                            n.valid[i] = 1'b0;
                        end
                    end
                end else if (!i_cmd.cs_n && !i_cke && op == `DBC_OP_BST) begin
                    n.mode = dbc_pkg::DBC_DPD;
                    n.valid = 64'h0;
                    n.bank = '0;
                    n.rd_on = 1'b0;
                    n.wr_on = 1'b0;
                end
            end
            dbc_pkg::DBC_AREF: begin
                n.mtmr = r.mtmr - 8'h01;
                if (r.mtmr <= 8'h01) begin
                    n.mode = dbc_pkg::DBC_NORM;
                end
            end
            dbc_pkg::DBC_SREF: begin
                if (i_cke) begin
                    n.mode = dbc_pkg::DBC_XSR;
                    n.mtmr = 8'(`DBC_XSR_CYC);
                end else if (r.mtmr <= 8'h01) begin
                    n.mtmr = 8'(`DBC_REFI_CYC);
                    n.rfc = r.rfc + 15'h0001;
                    n.rfa = r.rfc;
                    n.rf_pulse = partial_array_refresh_select_keep(i_partial_array_refresh_select,
                                           r.rfc[14:13], r.rfc[12:11]);
                end else begin
                    n.mtmr = r.mtmr - 8'h01;
                end
            end
            dbc_pkg::DBC_XSR: begin
                n.mtmr = r.mtmr - 8'h01;
                if (r.mtmr <= 8'h01) begin
                    n.mode = dbc_pkg::DBC_NORM;
                end
            end
            dbc_pkg::DBC_DPD: begin
                if (i_cke) begin
                    n.mode = dbc_pkg::DBC_NORM;
                end
            end
            default: begin
                n.mode = dbc_pkg::DBC_NORM;
            end
        endcase
    end

    // State register with synchronous reset
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            r <= '0;
            r.mode <= dbc_pkg::DBC_NORM;
        end else begin
            r <= n;
        end
    end

    // Outputs straight from the state
    assign o_dq = r.dq;
    assign o_dq_oe = r.dq_oe;
    assign o_dqs = r.dqs;
    assign o_dqs_oe = r.dqs_oe;
    assign o_rd_valid = r.rd_vld;
    assign o_rfsh_pulse = r.rf_pulse;
    assign o_rfsh_addr = r.rfa;
    assign o_self_refresh = (r.mode == dbc_pkg::DBC_SREF);
    assign o_power_down = (r.mode == dbc_pkg::DBC_DPD);
    assign o_bank_open = {r.bank[3].open, r.bank[2].open, r.bank[1].open, r.bank[0].open};

endmodule

// file: common/dbc_consts.svh
// Offsets, field positions, encodings and timing counts of the bank command logic
`ifndef DBC_CONSTS_SVH
`define DBC_CONSTS_SVH

// Clock rate in MHz
`define DBC_MCLK_MHZ 25

// Address field positions
`define DBC_A_AP 10
`define DBC_COL_W 10

// Command encodings as {ras_n, cas_n, we_n}
`define DBC_OP_ACT 3'h3
`define DBC_OP_READ 3'h5
`define DBC_OP_WRITE 3'h4
`define DBC_OP_PRE 3'h2
`define DBC_OP_REF 3'h1
`define DBC_OP_BST 3'h6

// Read latency and burst length in words
`define DBC_CAS_LAT 3
`define DBC_BL 4

// Partial-array selections
`define DBC_PARTIAL_ARRAY_REFRESH_SELECT_FULL 3'h0
`define DBC_PARTIAL_ARRAY_REFRESH_SELECT_HALF 3'h1
`define DBC_PARTIAL_ARRAY_REFRESH_SELECT_QUARTER 3'h2
`define DBC_PARTIAL_ARRAY_REFRESH_SELECT_EIGHTH 3'h3
`define DBC_PARTIAL_ARRAY_REFRESH_SELECT_SIXTEENTH 3'h4

// Times in ns, or ps for the refresh interval
`define DBC_T_RP_NS 24
`define DBC_T_RAS_NS 42
`define DBC_T_RFC_NS 72
`define DBC_T_XSR_NS 112
`define DBC_T_REFI_PS 7812500

// Least times round up, the refresh interval rounds down
`define DBC_RP_CYC ((`DBC_T_RP_NS * `DBC_MCLK_MHZ + 999) / 1000)
`define DBC_RAS_CYC ((`DBC_T_RAS_NS * `DBC_MCLK_MHZ + 999) / 1000)
`define DBC_RFC_CYC ((`DBC_T_RFC_NS * `DBC_MCLK_MHZ + 999) / 1000)
`define DBC_XSR_CYC ((`DBC_T_XSR_NS * `DBC_MCLK_MHZ + 999) / 1000)
`define DBC_REFI_CYC (`DBC_T_REFI_PS * `DBC_MCLK_MHZ / 1000000)

`endif

// file: common/dbc_pkg.sv
// Types shared by the bank command logic
package dbc_pkg;

    typedef enum logic [4:0] {
        DBC_NORM = 5'h01,
        DBC_AREF = 5'h02,
        DBC_SREF = 5'h04,
        DBC_XSR = 5'h08,
        DBC_DPD = 5'h10
    } dbc_mode_e;

    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
    } dbc_cmd_s;

    typedef struct packed {
        logic open;
        logic pre;
        logic ap;
        logic [12:0] row;
        logic [3:0] tmr;
        logic [3:0] ras;
    } dbc_bank_s;

    typedef struct packed {
        logic [63:0][15:0] arr;
        logic [15:0] q;
    } dbc_mem_s;

    typedef struct packed {
        dbc_mode_e mode;
        logic [7:0] mtmr;
        dbc_bank_s [3:0] bank;
        logic [14:0] rfc;
        logic [14:0] rfa;
        logic rf_pulse;
        logic last_wr;
        logic rd_on;
        logic rd_ap;
        logic [1:0] rd_ba;
        logic [9:0] rd_col;
        logic [2:0] rd_cnt;
        logic infl;
        logic infl_ok;
        logic [1:0][15:0] buf_d;
        logic [1:0] bcnt;
        logic [1:0] lat;
        logic rd_vld;
        logic [15:0] dq;
        logic dq_oe;
        logic dqs;
        logic dqs_oe;
        logic wr_on;
        logic wr_ap;
        logic [1:0] wr_ba;
        logic [9:0] wr_col;
        logic [2:0] wr_cnt;
        logic [63:0] valid;
    } dbc_core_s;

endpackage

// file: hw/dbc_mem.sv
// Small storage array with byte write enables and registered read data
`timescale 1ns/1ps
module dbc_mem (
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_we,
    input wire logic [1:0] i_be,
    input wire logic [5:0] i_waddr,
    input wire logic [15:0] i_wdata,
    input wire logic i_re,
    input wire logic [5:0] i_raddr,
    output logic [15:0] o_rdata
);

    dbc_pkg::dbc_mem_s r;
    dbc_pkg::dbc_mem_s n;

    // Byte-masked write, registered read
    always_comb begin
        n = r;
        if (i_we && i_be[0]) begin
            n.arr[i_waddr][7:0] = i_wdata[7:0];
        end
        if (i_we && i_be[1]) begin
            n.arr[i_waddr][15:8] = i_wdata[15:8];
        end
        if (i_re) begin
            n.q = r.arr[i_raddr];
        end
    end

    // Array content is not cleared by reset
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            r.q <= 16'h0000;
        end else begin
            r <= n;
        end
    end

    assign o_rdata = r.q;

endmodule

// file: sim/dbc_core_sva.sv
// Port assertions of the bank command logic
`timescale 1ns/1ps
`include "dbc_consts.svh"
module dbc_core_sva (
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_cke,
    input wire dbc_pkg::dbc_cmd_s i_cmd,
    input wire logic [1:0] i_ba,
    input wire logic [12:0] i_addr,
    input wire logic i_rd_ready,
    input wire logic [15:0] o_dq,
    input wire logic o_dq_oe,
    input wire logic o_dqs,
    input wire logic o_dqs_oe,
    input wire logic o_rd_valid,
    input wire logic [3:0] o_bank_open,
    input wire logic o_rfsh_pulse,
    input wire logic o_self_refresh,
    input wire logic o_power_down
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_resetn);
    logic [2:0] op;
    logic sel;
    // Command code and selection seen at the pins
    assign op = {i_cmd.ras_n, i_cmd.cas_n, i_cmd.we_n};
    assign sel = !i_cmd.cs_n && !o_self_refresh && !o_power_down;
    sequence s_pre;
        o_dqs_oe && !o_dqs && !o_dq_oe;
    endsequence
    sequence s_word;
        o_rd_valid && o_dq_oe && o_dqs;
    endsequence
    property p_act_open;
        sel && i_cke && op == `DBC_OP_ACT && !o_bank_open[i_ba] |=> o_bank_open[$past(i_ba)];
    endproperty
    property p_pre_one;
        sel && i_cke && op == `DBC_OP_PRE && !i_addr[10] |=> !o_bank_open[$past(i_ba)];
    endproperty
    property p_pre_all;
        sel && i_cke && op == `DBC_OP_PRE && i_addr[10] |=> o_bank_open == 4'h0;
    endproperty
    property p_pre_keep;
        sel && i_cke && op == `DBC_OP_PRE && !i_addr[10] |=>
            (o_bank_open | (4'h1 << $past(i_ba))) == ($past(o_bank_open) | (4'h1 << $past(i_ba)));
    endproperty
    property p_rd_lat;
        sel && i_cke && op == `DBC_OP_READ && o_bank_open[i_ba] && !o_dqs_oe ##1 i_rd_ready [*3]
            |-> s_pre ##1 s_word;
    endproperty
    property p_rd_end;
        $fell(o_dq_oe) |-> o_dqs_oe && o_dq == 16'h0000 ##1 !o_dqs_oe;
    endproperty
    property p_rfsh;
        sel && i_cke && op == `DBC_OP_REF |=> o_rfsh_pulse ##1 !o_rfsh_pulse;
    endproperty
    property p_sref;
        sel && !i_cke && op == `DBC_OP_REF |-> ##[1:2] o_self_refresh;
    endproperty
    property p_sref_hold;
        o_self_refresh && !i_cke |=> o_self_refresh;
    endproperty
    property p_dpd;
        sel && !i_cke && op == `DBC_OP_BST |-> ##[1:2] (o_power_down && !o_self_refresh);
    endproperty
    a_act_open: assert property (p_act_open) else $error("bank not opened");
    a_pre_one: assert property (p_pre_one) else $error("bank not closed");
    a_pre_all: assert property (p_pre_all) else $error("banks not all closed");
    a_pre_keep: assert property (p_pre_keep) else $error("other bank changed");
    a_rd_lat: assert property (p_rd_lat) else $error("read timing wrong");
    a_rd_end: assert property (p_rd_end) else $error("release wrong");
    a_rfsh: assert property (p_rfsh) else $error("no refresh pulse");
    a_sref: assert property (p_sref) else $error("no self refresh");
    a_sref_hold: assert property (p_sref_hold) else $error("self refresh left");
    a_dpd: assert property (p_dpd) else $error("no power down");
endmodule
bind dbc_core dbc_core_sva u_sva (
    .i_mclk(i_mclk), .i_resetn(i_resetn), .i_cke(i_cke), .i_cmd(i_cmd), .i_ba(i_ba),
    .i_addr(i_addr), .i_rd_ready(i_rd_ready), .o_dq(o_dq), .o_dq_oe(o_dq_oe), .o_dqs(o_dqs),
    .o_dqs_oe(o_dqs_oe), .o_rd_valid(o_rd_valid), .o_bank_open(o_bank_open),
    .o_rfsh_pulse(o_rfsh_pulse), .o_self_refresh(o_self_refresh), .o_power_down(o_power_down)
);

// file: sim/dbc_ctrl_model.sv
// Memory controller model: commands, write data and read receiver
`timescale 1ns/1ps
module dbc_ctrl_model (
    input wire logic i_mclk,
    input wire logic [15:0] i_dq,
    input wire logic i_rd_valid,
    output dbc_pkg::dbc_cmd_s o_cmd,
    output logic o_cke,
    output logic [1:0] o_ba,
    output logic [12:0] o_addr,
    output logic [15:0] o_dq,
    output logic [1:0] o_dm,
    output logic o_rd_ready
);
    logic [15:0] rxq[$];
    // Idle pins: NOP, clock enabled, bytes masked
    initial begin
        o_cmd = 4'h7;
        o_cke = 1'b1;
        o_ba = 2'h0;
        o_addr = 13'h0000;
        o_dq = 16'h0000;
        o_dm = 2'h3;
        o_rd_ready = 1'b1;
    end
    // Receiver takes a word when valid meets ready
    always @(posedge i_mclk) begin
        if (i_rd_valid === 1'b1 && o_rd_ready) begin
            rxq.push_back(i_dq);
        end
    end
    // One command, then n NOP cycles carrying write words and receiver stall
    task automatic send(input logic [2:0] op, input logic [1:0] ba, input logic [12:0] a,
                        input logic ck, input int n, input int st, input logic [63:0] d,
                        input logic [7:0] m);
        @(posedge i_mclk);
        o_cmd <= {1'b0, op};
        o_cke <= ck;
        o_ba <= ba;
        o_addr <= a;
        for (int k = 0; k < n; k++) begin
            @(posedge i_mclk);
            o_cmd <= 4'h7;
            o_dq <= d[16 * (k % 4) +: 16];
            o_dm <= (k < 4) ? m[2 * (k % 4) +: 2] : 2'h3;
            o_rd_ready <= (k >= st);
        end
        @(posedge i_mclk);
        o_dq <= ~o_dq;
        o_rd_ready <= 1'b1;
    endtask
endmodule

// file: sim/tb_top.sv
// Self-checking testbench of the bank command logic
`timescale 1ns/1ps
`include "dbc_consts.svh"
module tb_top;
    localparam logic [63:0] D0 = 64'h4444_3333_2222_1111;
    localparam logic [63:0] D1 = 64'hDDDD_CCCC_BBBB_AAAA;
    localparam logic [63:0] DM = 64'h44DD_CC33_2222_AAAA;
    logic i_mclk;
    logic i_resetn;
    logic [2:0] pa_sel;
    dbc_pkg::dbc_cmd_s cmd;
    logic cke;
    logic [1:0] ba;
    logic [12:0] addr;
    logic [15:0] wdq;
    logic [1:0] dm;
    logic rdy;
    logic [15:0] rdq;
    logic rvld;
    logic [3:0] bopen;
    logic rfp;
    logic [14:0] rfa;
    logic sref;
    logic pdn;
    int miscompares = 0;
    int check_count = 0;
    int cycles = 0;
    int rf_n = 0;
    logic [14:0] rf_last = 15'h0000;
    dbc_core dut (
        .i_mclk(i_mclk), .i_resetn(i_resetn), .i_cke(cke), .i_cmd(cmd), .i_ba(ba),
        .i_addr(addr), .i_dq(wdq), .i_dm(dm), .i_rd_ready(rdy),
        .i_partial_array_refresh_select(pa_sel), .o_dq(rdq), .o_dq_oe(), .o_dqs(),
        .o_dqs_oe(), .o_rd_valid(rvld), .o_bank_open(bopen), .o_rfsh_pulse(rfp),
        .o_rfsh_addr(rfa), .o_self_refresh(sref), .o_power_down(pdn)
    );
    dbc_ctrl_model ctl (
        .i_mclk(i_mclk), .i_dq(rdq), .i_rd_valid(rvld), .o_cmd(cmd), .o_cke(cke),
        .o_ba(ba), .o_addr(addr), .o_dq(wdq), .o_dm(dm), .o_rd_ready(rdy)
    );
    // Clock
    initial begin
        i_mclk = 1'b0;
        forever #20 i_mclk = ~i_mclk;
    end
    // Refresh pulse capture and hang guard
    always @(posedge i_mclk) begin
        cycles <= cycles + 1;
        if (rfp === 1'b1) begin
            rf_n <= rf_n + 1;
            rf_last <= rfa;
        end
        if (cycles == 40000) begin
            miscompares = miscompares + 1;
            results();
        end
    end
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic op(input logic [2:0] c, input logic [1:0] b, input logic [12:0] a, input int n);
        ctl.send(c, b, a, 1'b1, n, 0, 64'h0, 8'hFF);
    endtask
    // Read one burst, stalling the receiver st cycles, and wait out auto precharge
    task automatic rd(input logic [1:0] b, input logic [12:0] a, input int st,
                      input logic [63:0] exp);
        logic [63:0] got;
        got = 64'h0;
        ctl.rxq.delete();
        ctl.send(`DBC_OP_READ, b, a, 1'b1, 8, st, 64'h0, 8'hFF);
        for (int w = 0; w < 30 && ctl.rxq.size() < 4; w++) @(posedge i_mclk);
        for (int i = 0; i < 4 && i < ctl.rxq.size(); i++) got[16 * i +: 16] = ctl.rxq[i];
        chk(got, exp);
        chk(ctl.rxq.size(), 4);
        for (int w = 0; w < 8 && a[10] && bopen[b]; w++) @(posedge i_mclk);
    endtask
    task automatic t_banks();
        for (int b = 0; b < 4; b++) op(`DBC_OP_ACT, b[1:0], 13'h0100, 2);
        chk(bopen, 4'hF);
        op(`DBC_OP_PRE, 2'h2, 13'h0000, 2);
        chk(bopen, 4'hB);
        op(`DBC_OP_PRE, 2'h2, 13'h0000, 2);
        chk(bopen, 4'hB);
        op(`DBC_OP_PRE, 2'h1, 13'h0400, 2);
        chk(bopen, 4'h0);
    endtask
    task automatic t_refresh();
        rf_n = 0;
        op(`DBC_OP_REF, 2'h3, 13'h1FFF, 3);
        op(`DBC_OP_REF, 2'h0, 13'h0000, 3);
        chk(rf_n, 2);
        chk(rf_last, 15'h0001);
    endtask
    task automatic t_mask();
        op(`DBC_OP_ACT, 2'h0, 13'h0000, 2);
        ctl.send(`DBC_OP_WRITE, 2'h0, 13'h0000, 1'b1, 6, 0, D0, 8'h00);
        ctl.send(`DBC_OP_WRITE, 2'h0, 13'h0000, 1'b1, 6, 0, D1, 8'h9C);
        rd(2'h0, 13'h0000, 0, DM);
        rd(2'h0, 13'h0400, 0, DM);
        chk(bopen[0], 1'b0);
        op(`DBC_OP_ACT, 2'h0, 13'h0000, 2);
        rd(2'h0, 13'h0000, 8, DM);
        // Second READ three cycles in: three old words, then the new burst from column 2
        ctl.rxq.delete();
        ctl.send(`DBC_OP_READ, 2'h0, 13'h0000, 1'b1, 1, 0, 64'h0, 8'hFF);
        ctl.send(`DBC_OP_READ, 2'h0, 13'h0002, 1'b1, 12, 0, 64'h0, 8'hFF);
        chk(ctl.rxq.size(), 7);
        chk({ctl.rxq[6], ctl.rxq[3]}, 32'h2222_CC33);
    endtask
    task automatic t_bst();
        ctl.rxq.delete();
        ctl.send(`DBC_OP_READ, 2'h0, 13'h0000, 1'b1, 1, 0, 64'h0, 8'hFF);
        op(`DBC_OP_BST, 2'h0, 13'h0000, 12);
        chk(ctl.rxq.size() < 4, 1'b1);
        chk(bopen[0], 1'b1);
    endtask
    task automatic t_sref();
        logic [12:0] rows[3] = '{13'h0000, 13'h1000, 13'h0800};
        op(`DBC_OP_PRE, 2'h0, 13'h0400, 2);
        for (int c = 0; c < 5; c++) begin
            pa_sel <= c[2:0];
            for (int j = 0; j < 3; j++) begin
                op(`DBC_OP_ACT, (j == 0) ? 2'h1 : 2'h0, rows[j], 2);
                ctl.send(`DBC_OP_WRITE, (j == 0) ? 2'h1 : 2'h0, 13'h0400, 1'b1, 8, 0,
                         D0, 8'h00);
            end
            ctl.send(`DBC_OP_REF, 2'h0, 13'h0000, 1'b0, 6, 0, 64'h0, 8'hFF);
            chk(sref, 1'b1);
            ctl.send(3'h7, 2'h0, 13'h0000, 1'b1, 4, 0, 64'h0, 8'hFF);
            chk(sref, 1'b0);
            for (int j = 0; j < 3; j++) begin
                op(`DBC_OP_ACT, (j == 0) ? 2'h1 : 2'h0, rows[j], 2);
                rd((j == 0) ? 2'h1 : 2'h0, 13'h0400, 0, (c < j + 2) ? D0 : 64'h0);
            end
        end
    endtask
    task automatic t_dpd();
        op(`DBC_OP_ACT, 2'h0, 13'h0000, 2);
        rd(2'h0, 13'h0400, 0, DM);
        ctl.send(`DBC_OP_BST, 2'h0, 13'h0000, 1'b0, 4, 0, 64'h0, 8'hFF);
        chk(pdn, 1'b1);
        ctl.send(3'h7, 2'h0, 13'h0000, 1'b1, 4, 0, 64'h0, 8'hFF);
        chk(pdn, 1'b0);
        op(`DBC_OP_ACT, 2'h0, 13'h0000, 2);
        rd(2'h0, 13'h0000, 0, 64'h0);
    endtask
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Reset, then each scenario in turn
    initial begin
        i_resetn = 1'b0;
        pa_sel = 3'h0;
        repeat (6) @(posedge i_mclk);
        i_resetn <= 1'b1;
        t_banks();
        t_refresh();
        t_mask();
        t_bst();
        t_sref();
        t_dpd();
        results();
    end
endmodule
